// [hw/switch_reset_strap_control.sv]
// Reset sequencing, strap capture and GPIO alternate outputs of the switch.
//
// Behaviour
// - GPIO 7 alternate function drives the active-low general purpose event output.
// - GPIO 8..11 alternate functions drive downstream resets for ports 1, 3, 5, 6.
// - GPIO 6 alternate function is reserved; pin stays input only.
// - Downstream common-clock strap reports shared reference clock on downstream ports.
// - Upstream common-clock strap reports shared reference clock on upstream port.
// - Master SMBus runs 100 kHz with slow strap, else 400 kHz; no override.
// - Active-low merge strap joins ports 0 and 1 into one x8 port.
// - When merged, port 1 lanes become lanes 4 to 7 of port 0.
// - Merge strap high keeps ports 0 and 1 as separate x4 ports.
// - Fundamental reset resets all logic and starts a fundamental reset.
// - Hold strap in reset keeps device halted after reset procedure, SMBus active.
// - Device leaves halted state only when SMBus master clears the hold bit.
// - Mode 0 is normal operation; mode 1 adds EEPROM configuration loading first.
// - EEPROM SMBus address comes from the four address strap pins.
`timescale 1ns/10ps
`default_nettype none

module switch_reset_strap_control
    import strap_ctrl_pkg::*;
(
    // Core clock and chip reset.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Fundamental reset pin, synchronous to clk.
    input  wire logic              fundamental_reset_n,
    // Board straps.
    input  wire logic              common_clk_down,
    input  wire logic              common_clk_up,
    input  wire logic              mgmt_master_slow,
    input  wire logic              port_merge_n,
    input  wire logic              reset_hold,
    input  wire logic [MODE_W-1:0] switch_op_mode,
    input  wire logic [ADDR_W-1:0] eeprom_bus_addr,
    // Switch control register hold bit as written over SMBus.
    input  wire logic              holdClearReq,
    // Core event and downstream reset requests from port logic.
    input  wire logic              gp_event,
    input  wire logic [3:0]        dnResetReq,
    // GPIO alternate function selects and pin input.
    input  wire logic [GPIO_W-1:0] gpioAltSel,
    input  wire logic [GPIO_W-1:0] gpioIn,
    // GPIO pad drive.
    output logic      [GPIO_W-1:0] gpioOut,
    output logic      [GPIO_W-1:0] gpioOe,
    // Named alternate outputs.
    output logic                   event_out_n,
    output logic                   dn1_reset_n,
    output logic                   dn3_reset_n,
    output logic                   dn5_reset_n,
    output logic                   dn6_reset_n,
    // Sequencer status.
    output logic                   coreReset,
    output logic                   holdBit,
    output logic                   eepromLoad,
    output logic                   switchRun,
    output logic                   modeValid,
    // Captured configuration.
    output logic                   dnCommonClk,
    output logic                   upCommonClk,
    output logic                   smbSlow,
    output logic      [SMB_DIV_W-1:0] smbHalfPeriod,
    output logic                   portsMerged,
    output logic      [LANE_W-1:0] port1LaneBase,
    output logic      [ADDR_W-1:0] eepromAddr,
    output logic      [MODE_W-1:0] opMode
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture.

    localparam int unsigned STRAP_W = 5 + MODE_W + ADDR_W;

    logic [STRAP_W-1:0] strapVec;
    logic               inFundReset;

    assign inFundReset = !fundamental_reset_n;

    strap_latch #(
        .WIDTH (STRAP_W)
    ) u_strap (
        .clk      (clk),
        .rst_n    (rst_n),
        .capture  (inFundReset),
        .strapIn  ({common_clk_down, common_clk_up, mgmt_master_slow, port_merge_n,
                    reset_hold, switch_op_mode, eeprom_bus_addr}),
        .strapOut (strapVec)
    );

    logic              capDn;
    logic              capUp;
    logic              capSlow;
    logic              capMergeN;
    logic              capHold;
    logic [MODE_W-1:0] capMode;
    logic [ADDR_W-1:0] capAddr;

    assign {capDn, capUp, capSlow, capMergeN, capHold, capMode, capAddr} = strapVec;

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer.

    seq_state_t          state_r;
    seq_state_t          state_nxt;
    logic [PROC_W-1:0]   procCnt_r;
    logic [PROC_W-1:0]   procCnt_nxt;
    logic                hold_r;
    logic                hold_nxt;

    always_comb
    begin
        state_nxt   = state_r;
        procCnt_nxt = procCnt_r;
        hold_nxt    = hold_r;
        case (state_r)
            ST_RESET:
            begin
                procCnt_nxt = '0;
                hold_nxt    = reset_hold;
                if (!inFundReset)
                    state_nxt = ST_PROC;
            end
            ST_PROC:
            begin
                procCnt_nxt = procCnt_r + PROC_W'(1);
                if (procCnt_r == PROC_W'(RESET_PROC_CYCLES - 1))
                    state_nxt = hold_r ? ST_HOLD : ST_RUN;
            end
            ST_HOLD:
            begin
                if (holdClearReq)
                begin
                    hold_nxt  = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN:
            begin
                state_nxt = ST_RUN;
            end
            default:
            begin
                state_nxt = ST_RESET;
            end
        endcase
        if (inFundReset)
        begin
            state_nxt = ST_RESET;
            hold_nxt  = reset_hold;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= ST_RESET;
            procCnt_r <= '0;
            hold_r    <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            procCnt_r <= procCnt_nxt;
            hold_r    <= hold_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    logic                  running;
    logic                  inReset;
    logic [GPIO_W-1:0]     gpioOut_nxt;
    logic [GPIO_W-1:0]     gpioOe_nxt;
    logic [3:0]            dnRstN_nxt;
    logic [3:0]            dnRstN_r;
    logic [GPIO_W-1:0]     gpioOut_r;
    logic [GPIO_W-1:0]     gpioOe_r;
    logic                  eventN_r;
    logic                  stat_r [0:4];
    logic                  cfgDn_r;
    logic                  cfgUp_r;
    logic                  cfgSlow_r;
    logic [SMB_DIV_W-1:0]  cfgHalf_r;
    logic                  cfgMerged_r;
    logic [LANE_W-1:0]     cfgBase_r;
    logic [ADDR_W-1:0]     cfgAddr_r;
    logic [MODE_W-1:0]     cfgMode_r;

    assign running = (state_r == ST_RUN);
    assign inReset = !running;

    always_comb
    begin
        dnRstN_nxt  = inReset ? 4'h0 : ~dnResetReq;
        gpioOut_nxt = '0;
        gpioOe_nxt  = '0;
        // Pin 6 and pins without an alternate output are never driven.
        gpioOut_nxt[PIN_EVENT] = !(gp_event && running);
        gpioOe_nxt[PIN_EVENT]  = gpioAltSel[PIN_EVENT];
        gpioOe_nxt[PIN_RSVD]   = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            gpioOut_nxt[PIN_DN_FIRST + i] = dnRstN_nxt[i];
            gpioOe_nxt[PIN_DN_FIRST + i]  = gpioAltSel[PIN_DN_FIRST + i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dnRstN_r    <= '0;
            gpioOut_r   <= '0;
            gpioOe_r    <= '0;
            eventN_r    <= 1'b1;
            stat_r[0]   <= 1'b1;
            stat_r[1]   <= 1'b0;
            stat_r[2]   <= 1'b0;
            stat_r[3]   <= 1'b0;
            stat_r[4]   <= 1'b0;
            cfgDn_r     <= 1'b0;
            cfgUp_r     <= 1'b0;
            cfgSlow_r   <= 1'b0;
            cfgHalf_r   <= SMB_DIV_W'(SMB_FAST_HALF);
            cfgMerged_r <= 1'b0;
            cfgBase_r   <= '0;
            cfgAddr_r   <= '0;
            cfgMode_r   <= MODE_NORMAL;
        end
        else
        begin
            dnRstN_r    <= dnRstN_nxt;
            gpioOut_r   <= gpioOut_nxt;
            gpioOe_r    <= gpioOe_nxt;
            eventN_r    <= gpioOut_nxt[PIN_EVENT];
            stat_r[0]   <= inReset;
            stat_r[1]   <= hold_nxt;
            stat_r[2]   <= running && (cfgMode_r == MODE_EEPROM);
            stat_r[3]   <= running;
            stat_r[4]   <= (capMode == MODE_NORMAL) || (capMode == MODE_EEPROM);
            cfgDn_r     <= capDn;
            cfgUp_r     <= capUp;
            cfgSlow_r   <= capSlow;
            cfgHalf_r   <= capSlow ? SMB_DIV_W'(SMB_SLOW_HALF) : SMB_DIV_W'(SMB_FAST_HALF);
            cfgMerged_r <= !capMergeN;
            cfgBase_r   <= capMergeN ? '0 : MERGE_LANE_BASE;
            cfgAddr_r   <= capAddr;
            cfgMode_r   <= capMode;
        end
    end

    assign gpioOut       = gpioOut_r;
    assign gpioOe        = gpioOe_r;
    assign event_out_n   = eventN_r;
    assign dn1_reset_n   = dnRstN_r[0];
    assign dn3_reset_n   = dnRstN_r[1];
    assign dn5_reset_n   = dnRstN_r[2];
    assign dn6_reset_n   = dnRstN_r[3];
    assign coreReset     = stat_r[0];
    assign holdBit       = stat_r[1];
    assign eepromLoad    = stat_r[2];
    assign switchRun     = stat_r[3];
    assign modeValid     = stat_r[4];
    assign dnCommonClk   = cfgDn_r;
    assign upCommonClk   = cfgUp_r;
    assign smbSlow       = cfgSlow_r;
    assign smbHalfPeriod = cfgHalf_r;
    assign portsMerged   = cfgMerged_r;
    assign port1LaneBase = cfgBase_r;
    assign eepromAddr    = cfgAddr_r;
    assign opMode        = cfgMode_r;

    // gpioIn is only observed by software; the reserved pin has no function.
    logic unusedIn;
    assign unusedIn = ^gpioIn;

endmodule
`default_nettype wire

// [common/strap_ctrl_pkg.sv]
// Constants and types shared by the reset and strap control block.
package strap_ctrl_pkg;

    // Clock rate and SMBus master speeds.
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned SMB_SLOW_HZ   = 100_000;
    localparam int unsigned SMB_FAST_HZ   = 400_000;
    // Half periods of the master SMBus clock, in core clock cycles, rounded down.
    localparam int unsigned SMB_SLOW_HALF = CLK_HZ / (2 * SMB_SLOW_HZ);
    localparam int unsigned SMB_FAST_HALF = CLK_HZ / (2 * SMB_FAST_HZ);
    localparam int unsigned SMB_DIV_W     = 8;

    // Field widths.
    localparam int unsigned MODE_W        = 3;
    localparam int unsigned ADDR_W        = 4;
    localparam int unsigned LANE_W        = 3;

    // Switch operating mode codes.
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_EEPROM    = 3'h1;

    // Lane numbering of merged port 0.
    localparam logic [2:0] MERGE_LANE_BASE = 3'h4;

    // Cycles that the fundamental reset procedure takes after release.
    localparam int unsigned RESET_PROC_CYCLES = 16;
    localparam int unsigned PROC_W            = 5;

    // Alternate function pin numbers.
    localparam int unsigned PIN_RSVD      = 6;
    localparam int unsigned PIN_EVENT     = 7;
    localparam int unsigned PIN_DN_FIRST  = 8;
    localparam int unsigned GPIO_W        = 12;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_PROC,
        ST_HOLD,
        ST_RUN
    } seq_state_t;

endpackage

// [hw/strap_latch.sv]
// Capture register for the board straps, loaded on every clock while fundamental reset is asserted.
`timescale 1ns/10ps
`default_nettype none

module strap_latch
    import strap_ctrl_pkg::*;
#(
    parameter int unsigned WIDTH = 8
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Capture control.
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] strapIn,
    output logic      [WIDTH-1:0] strapOut
);

    logic [WIDTH-1:0] hold_r;
    logic [WIDTH-1:0] hold_nxt;

    always_comb
    begin
        hold_nxt = capture ? strapIn : hold_r;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_r <= '0;
        else
            hold_r <= hold_nxt;
    end

    assign strapOut = hold_r;

endmodule
`default_nettype wire

// [tb/srsc_checker_properties.sv]
// Concurrent checks on the ports of the reset and strap control block.
`timescale 1ns/10ps
`default_nettype none

module srsc_checker
    import strap_ctrl_pkg::*;
(
    // Clock, resets and requests.
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              fundamental_reset_n,
    input wire logic              holdClearReq,
    input wire logic              gp_event,
    input wire logic [3:0]        dnResetReq,
    input wire logic [GPIO_W-1:0] gpioAltSel,
    // Observed outputs.
    input wire logic [GPIO_W-1:0] gpioOut,
    input wire logic [GPIO_W-1:0] gpioOe,
    input wire logic              event_out_n,
    input wire logic              dn1_reset_n,
    input wire logic              dn3_reset_n,
    input wire logic              dn5_reset_n,
    input wire logic              dn6_reset_n,
    input wire logic              coreReset,
    input wire logic              holdBit,
    input wire logic              switchRun,
    input wire logic              smbSlow,
    input wire logic [SMB_DIV_W-1:0] smbHalfPeriod,
    input wire logic              portsMerged,
    input wire logic [LANE_W-1:0] port1LaneBase,
    input wire logic [ADDR_W-1:0] eepromAddr,
    input wire logic [MODE_W-1:0] opMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    a_core_reset_entry: assert property (!fundamental_reset_n |-> ##2 coreReset)
        else $error("core reset not raised");
    a_proc_length: assert property ($rose(fundamental_reset_n) |-> !switchRun [*8] ##1 !switchRun [*8])
        else $error("reset procedure too short");
    a_proc_exit: assert property ($rose(fundamental_reset_n) ##1 fundamental_reset_n [*8] ##1
        fundamental_reset_n [*8] ##1 fundamental_reset_n [*4] |-> switchRun ^ holdBit)
        else $error("no run or hold after procedure");
    a_hold_not_run: assert property (holdBit |=> !switchRun)
        else $error("running while held");
    a_hold_release: assert property (holdBit && holdClearReq |-> ##[1:3] switchRun)
        else $error("hold clear not honoured");
    a_event_out: assert property ($past(rst_n) |-> event_out_n == !($past(gp_event) && switchRun))
        else $error("event output wrong");
    a_dn_resets: assert property ($past(rst_n) |-> {dn6_reset_n, dn5_reset_n, dn3_reset_n, dn1_reset_n}
        == ({4{switchRun}} & ~$past(dnResetReq)))
        else $error("downstream reset wrong");
    a_alt_enable: assert property ($past(rst_n) |-> gpioOe == {$past(gpioAltSel[11:7]), 7'h00})
        else $error("pad enable wrong");
    a_pin_route: assert property ((gpioOut[11:7] & gpioOe[11:7]) == ({dn6_reset_n, dn5_reset_n,
        dn3_reset_n, dn1_reset_n, event_out_n} & gpioOe[11:7]))
        else $error("pad drive wrong");
    a_lane_base: assert property (port1LaneBase == (portsMerged ? MERGE_LANE_BASE : 3'h0))
        else $error("lane base wrong");
    a_smb_rate: assert property (smbHalfPeriod == (smbSlow ? 8'(SMB_SLOW_HALF) : 8'(SMB_FAST_HALF)))
        else $error("master bus rate wrong");
    a_straps_held: assert property (fundamental_reset_n [*3] |-> $stable(opMode) && $stable(eepromAddr)
        && $stable(portsMerged) && $stable(smbSlow))
        else $error("captured straps moved");
endmodule

bind switch_reset_strap_control srsc_checker chk_u (
    .clk (clk), .rst_n (rst_n), .fundamental_reset_n (fundamental_reset_n),
    .holdClearReq (holdClearReq), .gp_event (gp_event), .dnResetReq (dnResetReq),
    .gpioAltSel (gpioAltSel), .gpioOut (gpioOut), .gpioOe (gpioOe), .event_out_n (event_out_n),
    .dn1_reset_n (dn1_reset_n), .dn3_reset_n (dn3_reset_n), .dn5_reset_n (dn5_reset_n),
    .dn6_reset_n (dn6_reset_n), .coreReset (coreReset), .holdBit (holdBit), .switchRun (switchRun),
    .smbSlow (smbSlow), .smbHalfPeriod (smbHalfPeriod), .portsMerged (portsMerged),
    .port1LaneBase (port1LaneBase), .eepromAddr (eepromAddr), .opMode (opMode)
);

`default_nettype wire

// [tb/strap_board_model.sv]
// Board side: strap pins and the host master that clears the hold bit.
`timescale 1ns/10ps
`default_nettype none

module strap_board_model
(
    // Bench control.
    input wire logic        clk,
    input wire logic [11:0] cfgWord,
    input wire logic        clearReq,
    // Straps and hold clear.
    output logic            common_clk_down,
    output logic            common_clk_up,
    output logic            mgmt_master_slow,
    output logic            port_merge_n,
    output logic            reset_hold,
    output logic [2:0]      switch_op_mode,
    output logic [3:0]      eeprom_bus_addr,
    output logic            holdClearReq
);
    // Straps follow the bench word on every clock, one cycle late; the block holds the captured mode after release.
    always @(posedge clk)
        {holdClearReq, switch_op_mode, eeprom_bus_addr, reset_hold, port_merge_n,
            mgmt_master_slow, common_clk_up, common_clk_down} <= #1 {clearReq, cfgWord};
endmodule

`default_nettype wire

// [tb/tb_switch_reset_strap_control.sv]
// Self-checking bench for the reset and strap control block.
`timescale 1ns/10ps
`default_nettype none

module tb_switch_reset_strap_control;
    import strap_ctrl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fundamental_reset_n = 1'b0, gp_event = 1'b0, clearReq = 1'b0;
    logic [3:0] dnResetReq = 4'h0;
    logic [GPIO_W-1:0] gpioAltSel = 12'h000, gpioIn = 12'h000, gpioOut, gpioOe;
    logic [11:0] cfgWord = 12'h000;
    logic common_clk_down, common_clk_up, mgmt_master_slow, port_merge_n, reset_hold, holdClearReq;
    logic [2:0] switch_op_mode, port1LaneBase, opMode;
    logic [3:0] eeprom_bus_addr, eepromAddr;
    logic event_out_n, dn1_reset_n, dn3_reset_n, dn5_reset_n, dn6_reset_n, coreReset, holdBit;
    logic eepromLoad, switchRun, modeValid, dnCommonClk, upCommonClk, smbSlow, portsMerged;
    logic [7:0] smbHalfPeriod;
    logic [11:0] cfgs [3] = '{12'h000, 12'h2a7, 12'hde9};
    int miscompares = 0, total_checks = 0, cycles = 0;

    switch_reset_strap_control dut_u (
        .clk (clk), .rst_n (rst_n), .fundamental_reset_n (fundamental_reset_n),
        .common_clk_down (common_clk_down), .common_clk_up (common_clk_up),
        .mgmt_master_slow (mgmt_master_slow), .port_merge_n (port_merge_n), .reset_hold (reset_hold),
        .switch_op_mode (switch_op_mode), .eeprom_bus_addr (eeprom_bus_addr), .holdClearReq (holdClearReq),
        .gp_event (gp_event), .dnResetReq (dnResetReq), .gpioAltSel (gpioAltSel), .gpioIn (gpioIn),
        .gpioOut (gpioOut), .gpioOe (gpioOe), .event_out_n (event_out_n), .dn1_reset_n (dn1_reset_n),
        .dn3_reset_n (dn3_reset_n), .dn5_reset_n (dn5_reset_n), .dn6_reset_n (dn6_reset_n),
        .coreReset (coreReset), .holdBit (holdBit), .eepromLoad (eepromLoad), .switchRun (switchRun),
        .modeValid (modeValid), .dnCommonClk (dnCommonClk), .upCommonClk (upCommonClk), .smbSlow (smbSlow),
        .smbHalfPeriod (smbHalfPeriod), .portsMerged (portsMerged), .port1LaneBase (port1LaneBase),
        .eepromAddr (eepromAddr), .opMode (opMode)
    );
    strap_board_model board_u (
        .clk (clk), .cfgWord (cfgWord), .clearReq (clearReq), .common_clk_down (common_clk_down),
        .common_clk_up (common_clk_up), .mgmt_master_slow (mgmt_master_slow), .port_merge_n (port_merge_n),
        .reset_hold (reset_hold), .switch_op_mode (switch_op_mode), .eeprom_bus_addr (eeprom_bus_addr),
        .holdClearReq (holdClearReq)
    );

    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            $display("[ERR] %0t run too long", $time);
            results();
        end
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic boot(input logic [11:0] cfg);
        fundamental_reset_n = 1'b0;
        cfgWord = cfg;
        tick(4);
        fundamental_reset_n = 1'b1;
        tick(20);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic straps_case(input logic [11:0] cfg);
        logic m;
        m = ~cfg[3];
        boot(cfg);
        check(dnCommonClk, cfg[0]);
        check(upCommonClk, cfg[1]);
        check(smbHalfPeriod, cfg[2] ? 12'(SMB_SLOW_HALF) : 12'(SMB_FAST_HALF));
        check(port1LaneBase, m ? MERGE_LANE_BASE : 3'h0);
        check(eepromAddr, cfg[8:5]);
        check({modeValid, eepromLoad}, {cfg[11:10] == 2'h0, cfg[11:9] == MODE_EEPROM});
        check({switchRun, coreReset}, 2'h2);
        cfgWord = ~cfg;
        tick(5);
        check({opMode, eepromAddr, portsMerged, smbSlow, upCommonClk, dnCommonClk},
            {cfg[11:5], m, cfg[2:0]});
    endtask

    task automatic hold_case();
        int i;
        boot(12'h018);
        check({switchRun, coreReset, holdBit, dn1_reset_n}, 4'h6);
        tick(30);
        check(switchRun, 1'b0);
        clearReq = 1'b1;
        tick(1);
        clearReq = 1'b0;
        for (i = 0; i < 8 && switchRun !== 1'b1; i++)
            tick(1);
        check({switchRun, holdBit}, 2'h2);
    endtask

    task automatic pins_case();
        logic [3:0] exp;
        logic ev;
        gpioAltSel = 12'hfff;
        for (int i = 0; i < 4; i++)
        begin
            exp = ~(4'h1 << i);
            ev = i[0];
            dnResetReq = ~exp;
            gp_event = ev;
            tick(2);
            check({dn6_reset_n, dn5_reset_n, dn3_reset_n, dn1_reset_n}, exp);
            check(gpioOut[11:7], {exp, !ev});
            check(event_out_n, !ev);
            check(gpioOe, 12'hf80);
        end
        gpioAltSel = 12'h000;
        tick(2);
        check(gpioOe, 12'h000);
        fundamental_reset_n = 1'b0;
        tick(3);
        check({coreReset, dn6_reset_n, dn5_reset_n, dn3_reset_n, dn1_reset_n}, 5'h10);
    endtask

    initial
    begin
        tick(16);
        rst_n = 1'b1;
        tick(2);
        foreach (cfgs[k])
            straps_case(cfgs[k]);
        hold_case();
        pins_case();
        results();
    end
endmodule

`default_nettype wire
